// ===== core/psc_stat_readout.sv
// Per-port statistics counters behind an indirect access window.
// Assumes a synchronous 8-bit register port and events from the switch
// datapath held until evReady, both on clk.
`timescale 1ns/100ps

module psc_stat_readout #(
  parameter int RAM_DEPTH = 256
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire psc_pkg::psc_reg_req_t regReq,
  output logic [7:0]                 regRdata,
  input  wire psc_pkg::psc_event_t   evIn,
  output logic                       evReady
);
  import psc_pkg::*;

  // Store address width; the map is cut to it at the store ports
  localparam int RAM_AW = $clog2(RAM_DEPTH);

  if (RAM_DEPTH < NUM_ENTRIES || RAM_DEPTH > (1 << ADDR_W)) begin : g_chk
    $error("psc_stat_readout: RAM_DEPTH cannot hold all counters");
  end

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    psc_fsm_t         fsm;
    logic [7:0]       tableSel;
    logic [7:0]       index;
    logic             pending;
    logic             opHost;
    logic [7:0]       opAddr;
    logic [AMT_W-1:0] opAmt;
    logic [4:0]       freezeMask;
    logic [4:0]       flushMask;
    logic [7:0]       walkAddr;
    logic [39:0]      result;
    logic [7:0]       rdata;
  } psc_state_t;

  psc_state_t st;
  psc_state_t next_st;

  logic [ENTRY_W-1:0] memRd;
  logic [7:0]         rdAddr;
  logic               wrEn;
  logic [7:0]         wrAddr;
  logic [ENTRY_W-1:0] wrData;
  logic [8:0]         hostMap;
  logic [8:0]         evMap;
  logic               tableOk;

  // ******************************************************************
  // Index helpers
  // ******************************************************************
  // Maps a table bit and index to {ok, store address}
  function automatic logic [8:0] mapIndex(logic hi, logic [7:0] idx);
    logic [8:0] r;
    r = '0;
    if (!hi) begin
      r = {idx < HI_BASE, idx};
    end else begin
      r = {idx < HI_LIMIT, 8'(HI_BASE + idx)};
    end
    return r;
  endfunction

  // Owning port of a store address
  function automatic logic [2:0] portOf(logic [7:0] a);
    logic [7:0] d;
    d = 8'(a - HI_BASE);
    return (a < HI_BASE) ? a[7:5] : d[4:2];
  endfunction

  function automatic psc_kind_t kindOf(logic [7:0] a);
    logic [7:0] d;
    d = 8'(a - HI_BASE);
    if (a < HI_BASE) begin
      return K_EVT;
    end
    return d[1] ? K_DROP : K_BYTE;
  endfunction

  // Adds to a counter; wraps at its width and makes overflow sticky
  function automatic logic [ENTRY_W-1:0] bump(logic [ENTRY_W-1:0] e,
                                              psc_kind_t k,
                                              logic [AMT_W-1:0] amt);
    logic [36:0] sum;
    logic [35:0] mask;
    sum  = {1'b0, e[35:0]} + 37'(amt);
    mask = (k == K_EVT) ? EVT_CNT_MASK :
           (k == K_BYTE) ? BYTE_CNT_MASK : DROP_CNT_MASK;
    return {e[36] | ((sum & ~{1'b0, mask}) != '0), sum[35:0] & mask};
  endfunction

  psc_counter_ram #(
    .WIDTH (ENTRY_W),
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk    (clk),
    .rst_n  (rst_n),
    .rdAddr (RAM_AW'(rdAddr)),
    .rdData (memRd),
    .wrEn   (wrEn),
    .wrAddr (RAM_AW'(wrAddr)),
    .wrData (wrData)
  );

  assign regRdata = st.rdata;

  // ******************************************************************
  // Next state
  // ******************************************************************
  // One store access at a time; an op takes two cycles so the store
  // never needs forwarding, at the cost of half the event rate.
  always_comb begin
    next_st = st;
    rdAddr  = st.opAddr;
    wrEn    = 1'b0;
    wrAddr  = st.opAddr;
    wrData  = '0;
    evReady = 1'b0;
    tableOk = (st.tableSel == TABLE_PORT_CTR) ||
              (st.tableSel == TABLE_HI_CTR);
    hostMap = mapIndex(st.tableSel == TABLE_HI_CTR, st.index);
    evMap   = mapIndex(evIn.hiBlock, evIn.index);
    unique case (st.fsm)
      S_IDLE: begin
        if (st.flushMask != 5'h00) begin
          next_st.fsm      = S_FLUSH;
          next_st.walkAddr = 8'h00;
        end else if (st.pending) begin
          next_st.pending = 1'b0;
          if (tableOk && hostMap[8]) begin
            rdAddr         = hostMap[7:0];
            next_st.opAddr = hostMap[7:0];
            next_st.opHost = 1'b1;
            next_st.fsm    = S_MOD;
          end
        end else begin
          // Stalls events while a read is pending or running
          evReady = 1'b1;
          if (evIn.valid && evMap[8] &&
              !st.freezeMask[portOf(evMap[7:0])]) begin
            rdAddr         = evMap[7:0];
            next_st.opAddr = evMap[7:0];
            next_st.opAmt  = evIn.amount;
            next_st.opHost = 1'b0;
            next_st.fsm    = S_MOD;
          end
        end
      end
      S_MOD: begin
        wrEn        = 1'b1;
        next_st.fsm = S_IDLE;
        if (st.opHost) begin
          wrData = '0;
          // Upper count bits are already zero for narrow kinds
          next_st.result = {1'b0, memRd[36], 1'b1, 1'b0,
                            memRd[35:0]};
        end else begin
          wrData = bump(memRd, kindOf(st.opAddr), st.opAmt);
        end
      end
      S_FLUSH: begin
        wrAddr = st.walkAddr;
        wrEn   = st.flushMask[portOf(st.walkAddr)];
        if (st.walkAddr == 8'(NUM_ENTRIES - 1)) begin
          next_st.flushMask = 5'h00;
          next_st.fsm       = S_IDLE;
        end else begin
          next_st.walkAddr = 8'(st.walkAddr + 8'h01);
        end
      end
    endcase
    // Register writes come last so a set beats a clear
    if (regReq.write) begin
      unique case (regReq.addr)
        OFS_TABLE_SEL:   next_st.tableSel = regReq.wdata;
        OFS_INDEX_TRIG: begin
          next_st.index   = regReq.wdata;
          next_st.pending = 1'b1;
          // A result landing now is kept; its counter is already clear
          if (!(st.fsm == S_MOD && st.opHost)) begin
            next_st.result = '0;
          end
        end
        OFS_STAT_FREEZE: next_st.freezeMask = regReq.wdata[4:0];
        OFS_STAT_FLUSH: begin
          next_st.flushMask = next_st.flushMask | regReq.wdata[4:0];
          // A port added mid-walk would miss the entries already passed
          if (st.fsm == S_FLUSH &&
              (regReq.wdata[4:0] & ~st.flushMask) != 5'h00) begin
            next_st.walkAddr = 8'h00;
          end
        end
        default: ;
      endcase
    end
    // Registered read data; unmapped offsets read zero
    if (regReq.read) begin
      unique case (regReq.addr)
        OFS_TABLE_SEL:   next_st.rdata = st.tableSel;
        OFS_INDEX_TRIG:  next_st.rdata = st.index;
        OFS_DATA_B4:     next_st.rdata = st.result[39:32];
        OFS_DATA_B3:     next_st.rdata = st.result[31:24];
        OFS_DATA_B2:     next_st.rdata = st.result[23:16];
        OFS_DATA_B1:     next_st.rdata = st.result[15:8];
        OFS_DATA_B0:     next_st.rdata = st.result[7:0];
        OFS_STAT_FREEZE: next_st.rdata = {3'h0, st.freezeMask};
        OFS_STAT_FLUSH:  next_st.rdata = {3'h0, st.flushMask};
        default:         next_st.rdata = 8'h00;
      endcase
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  // Reset starts a flush of every port so the store begins at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.fsm        <= S_FLUSH;
      st.tableSel   <= RST_TABLE_SEL;
      st.index      <= RST_INDEX;
      st.freezeMask <= RST_FREEZE;
      st.flushMask  <= 5'h1f;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic       wrTrig;
  logic [8:0] trigMap;
  assign wrTrig  = regReq.write && regReq.addr == OFS_INDEX_TRIG;
  // Map of the index being written, to tell a servable trigger
  assign trigMap = mapIndex(st.tableSel == TABLE_HI_CTR, regReq.wdata);

  a_result_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    st.result[39] == 1'b0 && st.result[36] == 1'b0)
    else $error("reserved result bits set");

  a_drop_fields: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == S_MOD && st.opHost && kindOf(st.opAddr) == K_DROP)
    |=> st.result[36:16] == 21'h0 && st.result[RES_VALID_BIT])
    else $error("drop result fields wrong");

  a_event_fields: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == S_MOD && st.opHost && kindOf(st.opAddr) == K_EVT)
    |=> st.result[36:30] == 7'h0)
    else $error("event result fields wrong");

  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == S_MOD && st.opHost) |-> wrEn && wrData == '0)
    else $error("read did not clear counter");

  a_trig_valid_low: assert property (@(posedge clk) disable iff (!rst_n)
    (wrTrig && st.fsm != S_MOD) |=> !st.result[RES_VALID_BIT])
    else $error("valid not dropped on trigger");

  a_trig_completes: assert property (@(posedge clk) disable iff (!rst_n)
    (wrTrig && st.fsm == S_IDLE && st.flushMask == 5'h00 && tableOk &&
     trigMap[8])
    |-> ##[1:4] (st.result[RES_VALID_BIT] || st.fsm == S_FLUSH ||
                 regReq.write))
    else $error("triggered read not finished in time");

  a_freeze_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (evReady && evIn.valid && evMap[8] &&
     st.freezeMask[portOf(evMap[7:0])])
    |=> !(st.fsm == S_MOD && !st.opHost))
    else $error("frozen port counted");

  a_flush_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm == S_FLUSH && wrEn) |-> wrData == '0 && wrAddr == st.walkAddr)
    else $error("flush wrote nonzero");

  a_stall_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (st.fsm != S_IDLE || st.pending) |-> !evReady)
    else $error("event taken while busy");

endmodule // psc_stat_readout

// ===== core/psc_pkg.sv
// Shared constants and types of the port statistics counter readout.
// Assumes one 100 MHz clock and an 8-bit register port in front of it.
package psc_pkg;

  // ******************************************************************
  // Geometry of the counter store
  // ******************************************************************
  localparam int NUM_PORTS   = 5;
  localparam int EVT_CTRS    = 32;
  localparam int HI_PER_PORT = 4;
  localparam int CTRS_PER_PORT = EVT_CTRS + HI_PER_PORT;
  localparam int NUM_ENTRIES = NUM_PORTS * CTRS_PER_PORT;
  localparam int ENTRY_W     = 37;
  localparam int ADDR_W      = 8;
  localparam int AMT_W       = 12;

  // First store word of the drop and byte block, and its index limit
  localparam logic [7:0] HI_BASE  = 8'ha0;
  localparam logic [7:0] HI_LIMIT = 8'h14;

  // ******************************************************************
  // Register offsets and reset values
  // ******************************************************************
  localparam logic [7:0] OFS_STAT_FREEZE = 8'h08;
  localparam logic [7:0] OFS_STAT_FLUSH  = 8'h09;
  localparam logic [7:0] OFS_TABLE_SEL   = 8'h6e;
  localparam logic [7:0] OFS_INDEX_TRIG  = 8'h6f;
  localparam logic [7:0] OFS_DATA_B4     = 8'h74;
  localparam logic [7:0] OFS_DATA_B3     = 8'h75;
  localparam logic [7:0] OFS_DATA_B2     = 8'h76;
  localparam logic [7:0] OFS_DATA_B1     = 8'h77;
  localparam logic [7:0] OFS_DATA_B0     = 8'h78;
  localparam logic [7:0] RST_TABLE_SEL   = 8'h00;
  localparam logic [7:0] RST_INDEX       = 8'h00;
  localparam logic [4:0] RST_FREEZE      = 5'h00;

  // Table select codes
  localparam logic [7:0] TABLE_PORT_CTR = 8'h1c;
  localparam logic [7:0] TABLE_HI_CTR   = 8'h1d;

  // ******************************************************************
  // Result layout and counter widths
  // ******************************************************************
  localparam int RES_OVF_BIT   = 38;
  localparam int RES_VALID_BIT = 37;
  localparam logic [35:0] EVT_CNT_MASK  = 36'h0_3fff_ffff;
  localparam logic [35:0] BYTE_CNT_MASK = 36'hf_ffff_ffff;
  localparam logic [35:0] DROP_CNT_MASK = 36'h0_0000_ffff;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psc_reg_req_t;

  typedef struct packed {
    logic             valid;
    logic             hiBlock;
    logic [7:0]       index;
    logic [AMT_W-1:0] amount;
  } psc_event_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_MOD   = 3'b010,
    S_FLUSH = 3'b100
  } psc_fsm_t;

  typedef enum logic [1:0] {
    K_EVT  = 2'b00,
    K_BYTE = 2'b01,
    K_DROP = 2'b10
  } psc_kind_t;

endpackage

// ===== core/psc_counter_ram.sv
// Simple dual-port store for the statistics counters.
// Read data come out of a register one clock after the address.
`timescale 1ns/100ps
module psc_counter_ram #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 256
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData
);

  // ******************************************************************
  // Storage
  // ******************************************************************
  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("psc_counter_ram: bad geometry");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Array itself has no reset; the owner clears it by a walk
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // psc_counter_ram

// ===== sim/psc_host_model.sv
// Host model: drives the register port of the statistics readout.
// Assumes one clk shared with the design; the bench calls its tasks.
`timescale 1ns/100ps
module psc_host_model (
  input  wire logic                  clk,
  output psc_pkg::psc_reg_req_t      regReq,
  input  wire logic [7:0]            regRdata
);
  import psc_pkg::*;

  // ******************************************************************
  // Register bus cycles
  // ******************************************************************
  // Idle bus from time zero
  initial regReq = '0;

  // One-cycle write strobe, changed just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regReq <= '0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    regReq <= '0;
    @(posedge clk);
    #1 d = regRdata;
  endtask

  // Select table, trigger, poll the valid flag, collect the bytes.
  // Reads follow at once, far inside the recommended interval
  task automatic fetch(input logic [7:0] tbl, input logic [7:0] idx,
                       input logic shortRead, output logic [39:0] res);
    logic [7:0] b;
    int         n;
    res = '0;
    wr(OFS_TABLE_SEL, tbl);
    wr(OFS_INDEX_TRIG, idx);
    for (n = 0; n < 20; n++) begin
      rd(OFS_DATA_B4, b);
      if (b[5] === 1'b1) break;
    end
    res[39:32] = b;
    // Drop counts skip the two upper count bytes
    if (shortRead !== 1'b1) begin
      rd(OFS_DATA_B3, res[31:24]);
      rd(OFS_DATA_B2, res[23:16]);
    end
    rd(OFS_DATA_B1, res[15:8]);
    rd(OFS_DATA_B0, res[7:0]);
  endtask
endmodule // psc_host_model

// ===== sim/psc_stat_readout_tb.sv
// Self-checking bench for the statistics counter readout.
// Assumes the host model drives the register port; events come from here.
`timescale 1ns/100ps
module psc_stat_readout_tb;
  import psc_pkg::*;

  // ******************************************************************
  // Clock, reset and instances
  // ******************************************************************
  logic         clk;
  logic         rst_n;
  psc_reg_req_t regReq;
  logic [7:0]   regRdata;
  psc_event_t   evIn;
  logic         evReady;
  int           badCount;
  int           totalChecks;
  logic [39:0]  r1;
  logic [39:0]  r2;

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  psc_stat_readout dut (
    .clk      (clk),
    .rst_n    (rst_n),
    .regReq   (regReq),
    .regRdata (regRdata),
    .evIn     (evIn),
    .evReady  (evReady)
  );

  psc_host_model host (
    .clk      (clk),
    .regReq   (regReq),
    .regRdata (regRdata)
  );

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  // Compare and count; four-state compare so X never matches
  task automatic chk(input string what, input logic [39:0] seen,
                     input logic [39:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Event held until taken; evReady is combinational, so look mid-cycle
  task automatic evt(input logic hi, input logic [7:0] idx,
                     input logic [11:0] amt);
    int n;
    @(posedge clk);
    evIn <= '{valid: 1'b1, hiBlock: hi, index: idx, amount: amt};
    @(negedge clk);
    for (n = 0; n < 400 && evReady !== 1'b1; n++) begin
      @(negedge clk);
    end
    if (n == 400) begin
      badCount++;
      conclude();
    end
    @(posedge clk);
    evIn <= '0;
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  // Reset values; writes to unmapped and read-only places are ignored
  task automatic t_reset;
    logic [7:0] b;
    logic [7:0] ofs [6];
    logic [7:0] want [6];
    ofs = '{OFS_TABLE_SEL, OFS_INDEX_TRIG, OFS_STAT_FREEZE,
            OFS_STAT_FLUSH, OFS_DATA_B4, 8'h50};
    // Reset starts a walk of all ports, shown pending while it runs
    want = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00};
    host.wr(8'h50, 8'h5a);
    host.wr(OFS_DATA_B4, 8'h5a);
    foreach (ofs[i]) begin
      host.rd(ofs[i], b);
      chk("reset value", {32'h0, b}, {32'h0, want[i]});
    end
    $display("test reset done");
  endtask

  // Event counters, port blocks, clear on read
  task automatic t_count;
    repeat (3) evt(1'b0, 8'h0d, 12'h001);
    repeat (2) evt(1'b0, 8'h2d, 12'h001);
    evt(1'b0, 8'h9f, 12'h001);
    host.fetch(TABLE_PORT_CTR, 8'h0d, 1'b0, r1);
    chk("port1 frames", r1, 40'h20_0000_0003);
    host.fetch(TABLE_PORT_CTR, 8'h0d, 1'b0, r1);
    chk("read clear", r1, 40'h20_0000_0000);
    host.fetch(TABLE_PORT_CTR, 8'h2d, 1'b0, r1);
    chk("port2 frames", r1, 40'h20_0000_0002);
    host.fetch(TABLE_PORT_CTR, 8'h9f, 1'b0, r1);
    chk("port5 last", r1, 40'h20_0000_0001);
    $display("test count done");
  endtask

  // Byte count passes 16 bits; drop count read short
  task automatic t_hi;
    repeat (17) evt(1'b1, 8'h00, 12'hfff);
    evt(1'b1, 8'h03, 12'h001);
    host.fetch(TABLE_HI_CTR, 8'h00, 1'b0, r1);
    chk("rx bytes", r1, 40'h20_0001_0fef);
    host.fetch(TABLE_HI_CTR, 8'h03, 1'b1, r1);
    chk("tx drops", r1, 40'h20_0000_0001);
    // Unknown table code: nothing is latched, valid stays low
    host.fetch(8'h00, 8'h0d, 1'b0, r1);
    chk("bad table", r1, 40'h00_0000_0000);
    $display("test hi done");
  endtask

  // Freeze one port, flush another
  task automatic t_ctrl;
    logic [7:0] b;
    int         n;
    host.wr(OFS_STAT_FREEZE, 8'h01);
    host.rd(OFS_STAT_FREEZE, b);
    chk("freeze reg", {32'h0000_0000, b}, 40'h00_0000_0001);
    evt(1'b0, 8'h0d, 12'h001);
    evt(1'b0, 8'h2d, 12'h001);
    host.wr(OFS_STAT_FREEZE, 8'h00);
    host.fetch(TABLE_PORT_CTR, 8'h0d, 1'b0, r1);
    chk("frozen port", r1, 40'h20_0000_0000);
    host.fetch(TABLE_PORT_CTR, 8'h2d, 1'b0, r1);
    chk("live port", r1, 40'h20_0000_0001);
    evt(1'b0, 8'h2d, 12'h001);
    host.wr(OFS_STAT_FLUSH, 8'h02);
    b = 8'hff;
    for (n = 0; n < 200 && b !== 8'h00; n++) begin
      host.rd(OFS_STAT_FLUSH, b);
    end
    chk("flush end", {32'h0000_0000, b}, 40'h00_0000_0000);
    host.fetch(TABLE_PORT_CTR, 8'h2d, 1'b0, r1);
    chk("flushed port", r1, 40'h20_0000_0000);
    $display("test ctrl done");
  endtask

  // Event racing a read lands in this read or the next, never lost
  task automatic t_race;
    logic [39:0] sum;
    evt(1'b0, 8'h05, 12'h001);
    fork
      host.fetch(TABLE_PORT_CTR, 8'h05, 1'b0, r1);
      evt(1'b0, 8'h05, 12'h001);
    join
    host.fetch(TABLE_PORT_CTR, 8'h05, 1'b0, r2);
    sum = {10'h000, r1[29:0]} + {10'h000, r2[29:0]};
    chk("race sum", sum, 40'h00_0000_0002);
    $display("test race done");
  endtask

  // Main sequence: reset held three cycles
  initial begin
    rst_n = 1'b0;
    evIn = '0;
    badCount = 0;
    totalChecks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_hi();
    t_ctrl();
    t_race();
    conclude();
  end

  // Watchdog far above the bench's run time
  initial begin
    #900000;
    badCount++;
    conclude();
  end
endmodule // psc_stat_readout_tb
